// ---- bench/link_quality_monitor_status_monitor.sv ----
// concurrent checks on the link quality monitor ports
`timescale 1ns/10ps
module link_quality_monitor_status_monitor (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        irq,
    input wire logic        linkResetReq,
    input wire logic        link100Valid
);
    wire logic       taken = hsel && htrans[1] && hready;
    wire logic       rdTk  = taken && !hwrite;
    wire logic       wrTk  = taken && hwrite;
    wire logic [7:0] idx   = haddr[9:2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence readStall;
        !hreadyout ##1 hreadyout;
    endsequence
    property rdZero(logic [7:0] i, logic [31:0] m);
        rdTk && idx == i |-> ##1 readStall ##0 (hrdata & m) == 32'h0;
    endproperty
    read_stall_a: assert property (rdTk |=> readStall)
        else $error("read data phase not two cycles");
    wr_ready_a: assert property (wrTk |=> hreadyout)
        else $error("write data phase stalled");
    mon_rsvd_a: assert property (rdZero(8'h1d, 32'hffff7c00))
        else $error("monitor reserved bits not zero");
    thr_rsvd_a: assert property (rdZero(8'h1e, 32'hffffd000))
        else $error("threshold strobe or reserved bits not zero");
    stat_rsvd_a: assert property (rdZero(8'h1f, 32'hfffffffe))
        else $error("status reserved bits not zero");
    unmap_zero_a: assert property (rdZero(8'h00, 32'hffffffff))
        else $error("unmapped read not zero");
    irq_fall_a: assert property ($fell(irq) |-> $past(wrTk, 2))
        else $error("irq dropped without a write");
    irq_rise_a: assert property ($rose(irq) |->
        $past(wrTk, 2) || $past(link100Valid))
        else $error("irq rose without link or write");
    pulse_once_a: assert property (linkResetReq |=> !linkResetReq)
        else $error("link reset request longer than one cycle");
    pulse_link_a: assert property (linkResetReq |-> $past(link100Valid))
        else $error("link reset request without link");
endmodule : link_quality_monitor_status_monitor
bind link_quality_monitor_status link_quality_monitor_status_monitor mon_u (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .irq(irq),
    .linkResetReq(linkResetReq), .link100Valid(link100Valid)
);

// ---- bench/link_quality_monitor_status_tb_top.sv ----
// testbench for the link quality monitor register block
`timescale 1ns/10ps
module link_quality_monitor_status_tb_top;
    import lqm_pkg::*;
    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic        link100Valid = 1'h1;
    logic        powerDown = 1'h0;
    param_t      pv [5] = '{default: 8'h18};
    logic        hreadyout, hresp, irq, linkResetReq;
    logic [31:0] hrdata, r;
    int          n_mismatch = 0, compares = 0, pulses = 0;
    always #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (linkResetReq === 1'h1) pulses++;
    link_quality_monitor_status dut_u (
        .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .eqCoeffParam(pv[0]), .gainCtrlParam(pv[1]),
        .baselineWanderParam(pv[2]), .freqOffsetParam(pv[3]),
        .freqCtrlParam(pv[4]), .link100Valid, .powerDown, .irq, .linkResetReq
    );
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [15:0] d);
        @(posedge ref_clk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, i, 2'h0};
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        bus(1'h0, i, 16'h0);
        check(r, e);
    endtask : rd
    task automatic irqIs(input logic e);
        @(negedge ref_clk);
        check({31'h0, irq}, {31'h0, e});
    endtask : irqIs
    task automatic viol(input int k, input logic [7:0] v);
        @(posedge ref_clk);
        pv[k] <= v;
        repeat (2) @(posedge ref_clk);
        pv[k] <= 8'h18;
    endtask : viol
    task automatic t_reset;
        rd(8'h1d, 32'h0);
        rd(8'h1e, 32'h80);
        bus(1'h1, 8'h1e, 16'h0100);
        rd(8'h1e, 32'h17f);
        rd(8'h00, 32'h0);
        check(32'(hresp), 32'h0);
        rd(8'h20, 32'h0);
        bus(1'h1, 8'h1d, 16'hffff);
        rd(8'h1d, 32'h8000);
    endtask : t_reset
    task automatic t_thresh;
        for (int k = 0; k < 5; k++) begin
            bus(1'h1, 8'h1e, 16'(32'h1010 | k << 9));
            rd(8'h1e, 32'h10 | k << 9);
            bus(1'h1, 8'h1e, 16'(32'h1120 | k << 9));
            rd(8'h1e, 32'h120 | k << 9);
            viol(k, 8'h30);
            rd(8'h1d, 32'h8000 | 2 << 2 * k);
            rd(8'h1d, 32'h8000);
            viol(k, 8'h08);
            rd(8'h1d, 32'h8000 | 1 << 2 * k);
            viol(k, 8'h20);
            viol(k, 8'h10);
            rd(8'h1d, 32'h8000);
        end
    endtask : t_thresh
    task automatic t_irq;
        irqIs(1'h0);
        bus(1'h1, 8'h20, 16'h1);
        irqIs(1'h1);
        bus(1'h1, 8'h1f, 16'h1);
        irqIs(1'h0);
        viol(0, 8'h30);
        irqIs(1'h1);
        rd(8'h1f, 32'h1);
        bus(1'h1, 8'h1f, 16'h1);
        viol(0, 8'h30);
        irqIs(1'h0);
        bus(1'h1, 8'h21, 16'h1);
        rd(8'h21, 32'h1);
        rd(8'h1d, 32'h8002);
        viol(0, 8'h30);
        irqIs(1'h1);
        check(32'(pulses), 32'h1);
        bus(1'h1, 8'h1f, 16'h1);
        rd(8'h1d, 32'h8002);
    endtask : t_irq
    task automatic t_gate;
        @(posedge ref_clk);
        link100Valid <= 1'h0;
        viol(1, 8'h30);
        rd(8'h1d, 32'h8000);
        @(posedge ref_clk);
        link100Valid <= 1'h1;
        bus(1'h1, 8'h1d, 16'h0);
        viol(1, 8'h30);
        rd(8'h1d, 32'h0);
    endtask : t_gate
    task automatic t_pdown;
        @(posedge ref_clk);
        powerDown <= 1'h1;
        bus(1'h1, 8'h1e, 16'h1055);
        @(posedge ref_clk);
        powerDown <= 1'h0;
        rd(8'h1e, 32'h10);
        bus(1'h1, 8'h1e, 16'h2400);
        rd(8'h1e, 32'h2418);
    endtask : t_pdown
    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        t_reset;
        t_thresh;
        t_irq;
        t_gate;
        t_pdown;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        stop_test;
    end
endmodule : link_quality_monitor_status_tb_top

// ---- pkg/lqm_defines.svh ----
// offsets, field positions, reset values of the link quality monitor
`ifndef LQM_DEFINES_SVH
`define LQM_DEFINES_SVH
`define LQM_IDX_MON        8'h1d
`define LQM_IDX_THR        8'h1e
`define LQM_IDX_IRQ_STAT   8'h1f
`define LQM_IDX_IRQ_MASK   8'h20
`define LQM_IDX_CTRL       8'h21
`define LQM_MON_EN_BIT     15
`define LQM_WARN_MSB       9
`define LQM_THR_SAMPLE_BIT 13
`define LQM_THR_WSTB_BIT   12
`define LQM_THR_PSEL_MSB   11
`define LQM_THR_PSEL_LSB   9
`define LQM_THR_TSEL_BIT   8
`define LQM_THR_DATA_MSB   7
`define LQM_IRQ_LQ_BIT     0
`define LQM_CTRL_ARST_BIT  0
`define LQM_NUM_PARAMS     5
`define LQM_THR_LOW_RESET  8'h80
`define LQM_THR_HIGH_RESET 8'h7f
`define LQM_WARN_RESET     10'h000
`endif

// ---- pkg/lqm_pkg.sv ----
// types shared by the link quality monitor
package lqm_pkg;
    typedef logic signed [7:0] param_t;
    typedef logic [9:0]        warn_t;
    typedef logic [15:0]       reg16_t;
    typedef enum logic [2:0] {
        PSEL_EQ_COEFF,
        PSEL_GAIN,
        PSEL_BLW,
        PSEL_FREQ_OFF,
        PSEL_FREQ_CTRL
    } param_sel_t;
endpackage : lqm_pkg

// ---- rtl/link_quality_monitor_status.sv ----
// link quality monitor registers, threshold checks and interrupt
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "lqm_defines.svh"

module link_quality_monitor_status (
    input  wire  logic           ref_clk,
    input  wire  logic           rst,
    input  wire  logic           hsel,
    input  wire  logic [31:0]    haddr,
    input  wire  logic [1:0]     htrans,
    input  wire  logic           hwrite,
    input  wire  logic [2:0]     hsize,
    input  wire  logic [31:0]    hwdata,
    input  wire  logic           hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    input  wire  lqm_pkg::param_t eqCoeffParam,
    input  wire  lqm_pkg::param_t gainCtrlParam,
    input  wire  lqm_pkg::param_t baselineWanderParam,
    input  wire  lqm_pkg::param_t freqOffsetParam,
    input  wire  lqm_pkg::param_t freqCtrlParam,
    input  wire  logic           link100Valid,
    input  wire  logic           powerDown,
    output logic                 irq,
    output logic                 linkResetReq
);
    import lqm_pkg::*;

    localparam int NP = `LQM_NUM_PARAMS;
    localparam int WARN_W = 2 * NP;
    localparam int PSEL_W = `LQM_THR_PSEL_MSB - `LQM_THR_PSEL_LSB + 1;

    // layout checks at elaboration
    if (NP != 5) begin : gNpCheck
        $error("monitor supports exactly five parameters");
    end
    if (WARN_W != $bits(warn_t)) begin : gWarnCheck
        $error("warning field does not fit the parameter count");
    end
    if (NP > (1 << PSEL_W)) begin : gSelCheck
        $error("parameter select field too narrow");
    end
    if ($bits(param_t) != `LQM_THR_DATA_MSB + 1) begin : gDataCheck
        $error("threshold data field differs from parameter width");
    end

    // threshold checks
    function automatic logic lowViol(input param_t v, input param_t lo);
        lowViol = (lo != param_t'(`LQM_THR_LOW_RESET)) && (v < lo);
    endfunction : lowViol

    function automatic logic highViol(input param_t v, input param_t hi);
        highViol = (hi != param_t'(`LQM_THR_HIGH_RESET)) && (v > hi);
    endfunction : highViol

    function automatic logic isIdx(input logic [7:0] a, input logic [7:0] i);
        isIdx = (a == i);
    endfunction : isIdx

    // bus state
    logic           rdPhase_reg;
    logic           wrPhase_reg;
    logic           rdDone_reg;
    logic [7:0]     addrIdx_reg;
    logic [31:0]    hrdata_reg;
    logic [31:0]    hrdata_next;

    // register state
    logic           monEnable_reg;
    warn_t          warn_reg;
    warn_t          warn_next;
    param_t         thrLow_reg  [NP];
    param_t         thrHigh_reg [NP];
    param_sel_t     paramSel_reg;
    logic           thrSel_reg;
    logic           sample_reg;
    param_t         sampled_reg;
    logic           irqStat_reg;
    logic           irqStat_next;
    logic           irqMask_reg;
    logic           autoReset_reg;
    logic           armed_reg;
    logic           armed_next;
    logic           linkResetReq_reg;

    // combinational nets
    wire            accept;
    wire            readStrobe;
    wire            writeStrobe;
    wire            monRead;
    wire            wrMon;
    wire            wrThr;
    wire            wrIrqStat;
    wire            wrIrqMask;
    wire            wrCtrl;
    wire            thrWriteOk;
    wire            active;
    wire            lqEvent;
    wire  [2:0]     wrPsel;
    wire            psValid;
    wire            thrLowWr;
    wire            thrHighWr;
    param_t         thrData;
    warn_t          viol;
    param_t         paramVal [NP];
    param_t         thrSelVal;
    param_t         curParam;
    reg16_t         monRdVal;
    reg16_t         thrRdVal;
    reg16_t         rdMux;

    assign paramVal[0] = eqCoeffParam;
    assign paramVal[1] = gainCtrlParam;
    assign paramVal[2] = baselineWanderParam;
    assign paramVal[3] = freqOffsetParam;
    assign paramVal[4] = freqCtrlParam;

    // ahb-lite slave decode
    assign accept      = hsel & htrans[1] & hready;
    assign readStrobe  = rdPhase_reg & ~rdDone_reg;
    assign writeStrobe = wrPhase_reg;
    assign hreadyout   = ~readStrobe;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_reg;
    assign hrdata_next = {16'h0000, rdMux};

    assign monRead   = readStrobe & isIdx(addrIdx_reg, `LQM_IDX_MON);
    assign wrMon     = writeStrobe & isIdx(addrIdx_reg, `LQM_IDX_MON);
    assign wrThr     = writeStrobe & isIdx(addrIdx_reg, `LQM_IDX_THR);
    assign wrIrqStat = writeStrobe & isIdx(addrIdx_reg, `LQM_IDX_IRQ_STAT);
    assign wrIrqMask = writeStrobe & isIdx(addrIdx_reg, `LQM_IDX_IRQ_MASK);
    assign wrCtrl    = writeStrobe & isIdx(addrIdx_reg, `LQM_IDX_CTRL);

    // threshold write path
    assign wrPsel     = hwdata[`LQM_THR_PSEL_MSB:`LQM_THR_PSEL_LSB];
    assign psValid    = (wrPsel <= 3'(PSEL_FREQ_CTRL));
    assign thrWriteOk = wrThr & hwdata[`LQM_THR_WSTB_BIT]
                        & psValid & ~powerDown;
    assign thrData    = param_t'(hwdata[`LQM_THR_DATA_MSB:0]);
    assign thrLowWr   = thrWriteOk & ~hwdata[`LQM_THR_TSEL_BIT];
    assign thrHighWr  = thrWriteOk & hwdata[`LQM_THR_TSEL_BIT];

    // monitoring and violation detection
    assign active = monEnable_reg & link100Valid;

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gChk
            // low at even bit, high at odd bit
            assign viol[2*g] = active
                & lowViol(paramVal[g], thrLow_reg[g]);
            assign viol[2*g+1] = active
                & highViol(paramVal[g], thrHigh_reg[g]);
        end
    endgenerate

    // warnings sticky until monitor read, new violation wins
    assign warn_next = (warn_reg & ~({10{monRead}})) | viol;

    // one interrupt event per arming
    assign lqEvent    = armed_reg & (|viol);
    assign armed_next = lqEvent ? 1'b0
                      : (monRead ? 1'b1 : armed_reg);

    // sticky status, write one clears, set wins
    assign irqStat_next = lqEvent
        | (irqStat_reg & ~(wrIrqStat & hwdata[`LQM_IRQ_LQ_BIT]));
    assign irq = irqStat_reg & irqMask_reg;

    // read values
    assign thrSelVal = thrSel_reg ? thrHigh_reg[paramSel_reg]
                                  : thrLow_reg[paramSel_reg];
    assign curParam  = paramVal[paramSel_reg];

    assign monRdVal = {monEnable_reg,
                       5'h00,
                       warn_reg[9:8],
                       warn_reg[7:6],
                       warn_reg[5:4],
                       warn_reg[3:2],
                       warn_reg[1:0]};
    assign thrRdVal = {2'h0, sample_reg, 1'b0,
                       paramSel_reg, thrSel_reg,
                       sample_reg ? sampled_reg : thrSelVal};

    assign rdMux =
        isIdx(addrIdx_reg, `LQM_IDX_MON)      ? monRdVal :
        isIdx(addrIdx_reg, `LQM_IDX_THR)      ? thrRdVal :
        isIdx(addrIdx_reg, `LQM_IDX_IRQ_STAT) ? {15'h0000, irqStat_reg} :
        isIdx(addrIdx_reg, `LQM_IDX_IRQ_MASK) ? {15'h0000, irqMask_reg} :
        isIdx(addrIdx_reg, `LQM_IDX_CTRL)     ? {15'h0000, autoReset_reg} :
        16'h0000;

    assign linkResetReq = linkResetReq_reg;

    // bus phase tracking
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdPhase_reg <= 1'b0;
            wrPhase_reg <= 1'b0;
            rdDone_reg  <= 1'b0;
            addrIdx_reg <= 8'h00;
        end else if (hready) begin
            rdPhase_reg <= accept & ~hwrite;
            wrPhase_reg <= accept & hwrite;
            rdDone_reg  <= 1'b0;
            addrIdx_reg <= haddr[9:2];
        end else if (readStrobe) begin
            rdDone_reg  <= 1'b1;
        end
    end

    // read data capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata_reg <= 32'h00000000;
        end else if (readStrobe) begin
            hrdata_reg <= hrdata_next;
        end
    end

    // monitor enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            monEnable_reg <= 1'b0;
        end else if (wrMon) begin
            monEnable_reg <= hwdata[`LQM_MON_EN_BIT];
        end
    end

    // sticky warnings
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            warn_reg <= `LQM_WARN_RESET;
        end else begin
            warn_reg <= warn_next;
        end
    end

    // threshold access selects
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            paramSel_reg <= PSEL_EQ_COEFF;
            thrSel_reg   <= 1'b0;
            sample_reg   <= 1'b0;
        end else if (wrThr) begin
            if (psValid) begin
                paramSel_reg <= param_sel_t'(wrPsel);
            end
            thrSel_reg <= hwdata[`LQM_THR_TSEL_BIT];
            sample_reg <= hwdata[`LQM_THR_SAMPLE_BIT];
        end
    end

    // threshold storage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NP; i++) begin
                thrLow_reg[i]  <= param_t'(`LQM_THR_LOW_RESET);
                thrHigh_reg[i] <= param_t'(`LQM_THR_HIGH_RESET);
            end
        end else begin
            if (thrLowWr) begin
                thrLow_reg[wrPsel] <= thrData;
            end
            if (thrHighWr) begin
                thrHigh_reg[wrPsel] <= thrData;
            end
        end
    end

    // parameter sampling for readback
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sampled_reg <= 8'sh00;
        end else if (sample_reg) begin
            sampled_reg <= curParam;
        end
    end

    // interrupt status
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqStat_reg <= 1'b0;
        end else begin
            irqStat_reg <= irqStat_next;
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqMask_reg <= 1'b0;
        end else if (wrIrqMask) begin
            irqMask_reg <= hwdata[`LQM_IRQ_LQ_BIT];
        end
    end

    // interrupt arming
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= armed_next;
        end
    end

    // auto link reset enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            autoReset_reg <= 1'b0;
        end else if (wrCtrl) begin
            autoReset_reg <= hwdata[`LQM_CTRL_ARST_BIT];
        end
    end

    // automatic 100Mb link reset request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            linkResetReq_reg <= 1'b0;
        end else begin
            linkResetReq_reg <= autoReset_reg & lqEvent;
        end
    end

endmodule : link_quality_monitor_status
